/* File: src/hsd_core.sv */
// Function
// [RULE_01] exclusive store: base address, low half, monitor-gated
// [RULE_02] exclusive status: zero stored, one failed
// [RULE_03] exclusive bad register combinations: executed as no-op
// [RULE_04] short form offset is five bits times two
// [RULE_05] short form: pre-index, add, never write back
// [RULE_06] wide forms with base fifteen are undefined; the unprivileged form is flagged unprivileged instead
// [RULE_07] wide forms undefined without mainline feature; the unprivileged form is flagged unprivileged instead
// [RULE_08] long offset zero-extended, added, no writeback
// [RULE_09] index, sign, update bits drive addressing
// [RULE_10] index+sign without update is unprivileged store; here only flagged in status, never stored
// [RULE_11] short offset zero-extended, zero to 255
// [RULE_12] bad source or writeback clash: no-op
// [RULE_13] offset address base +/- imm; index picks it
// [RULE_14] stack base writeback: store only at or above limit
// [RULE_15] writeback via limit-checked path, violation faults
// [RULE_16] every store writes two bytes from bits 15:0
// [RULE_17] exclusive access alignment-checked, plain may be unaligned
`timescale 1ns/1ps
`include "hsd_map.svh"
module hsd_core (
    input  wire logic           aclk,
    input  wire logic           aresetn,
    input  wire logic [7:0]     awaddr,
    input  wire logic           awvalid,
    output logic                awready,
    input  wire logic [31:0]    wdata,
    input  wire logic [3:0]     wstrb,
    input  wire logic           wvalid,
    output logic                wready,
    output logic [1:0]          bresp,
    output logic                bvalid,
    input  wire logic           bready,
    input  wire logic [7:0]     araddr,
    input  wire logic           arvalid,
    output logic                arready,
    output logic [31:0]         rdata,
    output logic [1:0]          rresp,
    output logic                rvalid,
    input  wire logic           rready,
    output hsd_pkg::hsd_mem_t   mem_o,
    output logic                excl_query,
    input  wire logic           excl_done,
    input  wire logic           excl_pass,
    output hsd_pkg::hsd_rwr_t   rwr_o,
    output logic                fault_o
);
    // high when register is sp or pc
    function automatic logic hsd_hi(input logic [3:0] r);
        return (r == `HSD_R_SP) || (r == `HSD_R_PC);
    endfunction : hsd_hi

    // byte-lane merge for every writable register except control
    function automatic logic [31:0] hsd_merge(input logic [31:0] o, input logic [31:0] n,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[i*8 +: 8] = n[i*8 +: 8];
        return r;
    endfunction : hsd_merge

    // instruction decode; first halfword low, second high
    function automatic hsd_pkg::hsd_dec_t hsd_decode(input logic [31:0] w, input logic mf);
        hsd_pkg::hsd_dec_t r;
        logic [15:0]       a;
        logic [15:0]       b;
        r = '0;
        a = w[15:0];
        b = w[31:16];
        if (a[15:11] == `HSD_E_SHORT)
        begin
            r.base_reg   = {1'b0, a[5:3]};
            r.source_reg = {1'b0, a[2:0]};
            r.imm   = {26'h0, a[10:6], 1'b0}; // RULE_04
            r.index = 1'b1; // RULE_05
            r.add   = 1'b1;
        end
        else if (a[15:4] == `HSD_E_EXCL && b[7:4] == `HSD_E_EXH2)
        begin
            r.excl   = 1'b1;
            r.base_reg   = a[3:0];
            r.source_reg = b[15:12];
            r.rd     = b[3:0];
            r.unpred = hsd_hi(r.rd) || hsd_hi(r.source_reg) || r.base_reg == `HSD_R_PC
                       || r.rd == r.base_reg || r.rd == r.source_reg; // RULE_03
        end
        else if (a[15:4] == `HSD_E_LONG)
        begin
            r.base_reg   = a[3:0];
            r.source_reg = b[15:12];
            r.imm    = {20'h0, b[11:0]}; // RULE_08
            r.index  = 1'b1;
            r.add    = 1'b1;
            r.undef  = r.base_reg == `HSD_R_PC || !mf; // RULE_06 RULE_07
            r.unpred = hsd_hi(r.source_reg); // RULE_12
        end
        else if (a[15:4] == `HSD_E_MODE && b[11])
        begin
            r.base_reg   = a[3:0];
            r.source_reg = b[15:12];
            r.imm    = {24'h0, b[7:0]}; // RULE_11
            r.index  = b[10]; // RULE_09
            r.add    = b[9];
            r.wback  = b[8];
            r.unpriv = b[10] && b[9] && !b[8]; // RULE_10
            r.undef  = !r.unpriv && (r.base_reg == `HSD_R_PC || !mf
                       || (!b[10] && !b[8])); // RULE_06 RULE_07
            r.unpred = hsd_hi(r.source_reg)
                       || (r.wback && r.base_reg == r.source_reg); // RULE_12
        end
        else
            r.undef = 1'b1; // not a halfword store at all
        return r;
    endfunction : hsd_decode

    // bus slave state
    logic              awready_q, awready_d;
    logic              wready_q, wready_d;
    logic [7:0]        awaddr_q, awaddr_d;
    logic [31:0]       wdata_q, wdata_d;
    logic [3:0]        wstrb_q, wstrb_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              arready_q, arready_d;
    logic              rvalid_q, rvalid_d;
    logic [31:0]       rdata_q, rdata_d;
    logic [1:0]        rresp_q, rresp_d;
    logic              wr_fire; // both halves held, response slot free
    // block state
    hsd_pkg::hsd_state_t st_q, st_d;
    hsd_pkg::hsd_dec_t   dec_q, dec_d;
    hsd_pkg::hsd_stat_t  stat_q, stat_d;
    hsd_pkg::hsd_mem_t   mem_q, mem_d;
    hsd_pkg::hsd_rwr_t   rwr_q, rwr_d;
    hsd_pkg::hsd_dec_t   dv;        // live decode of the held word
    logic              main_q, main_d; // mainline feature present
    logic [31:0]       insn_q, insn_d;
    logic [31:0]       src_q, src_d;   // source register value
    logic [31:0]       base_q, base_d; // base register value
    logic [31:0]       splim_q, splim_d;
    logic [31:0]       addr_q, addr_d; // access address
    logic [31:0]       wbv_q, wbv_d;   // offset address
    logic              xq_q, xq_d;
    logic              xok_q, xok_d;
    logic              fault_q, fault_d;
    logic              viol;           // stack limit violated

    assign wr_fire = !awready_q && !wready_q && !bvalid_q;
    assign dv      = hsd_decode(insn_q, main_q);
    // limit only applies on stack-pointer writeback
    assign viol    = dec_q.base_reg == `HSD_R_SP && dec_q.wback && wbv_q < splim_q; // RULE_14

    // bus slave next state: address and data taken in either order
    always_comb
    begin
        awready_d = awready_q;
        wready_d  = wready_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (awvalid && awready_q)
        begin
            awready_d = 1'b0;
            awaddr_d  = awaddr;
        end
        if (wvalid && wready_q)
        begin
            wready_d = 1'b0;
            wdata_d  = wdata;
            wstrb_d  = wstrb;
        end
        if (bvalid_q && bready)
            bvalid_d = 1'b0;
        if (wr_fire)
        begin
            awready_d = 1'b1;
            wready_d  = 1'b1;
            bvalid_d  = 1'b1;
            bresp_d   = `HSD_OKAY;
            // read-only and unmapped words answer with an error
            if (!({awaddr_q[7:2], 2'h0} inside {`HSD_A_CTRL, `HSD_A_INSN, `HSD_A_SRC,
                                                 `HSD_A_BASE, `HSD_A_SPLIM}))
                bresp_d = `HSD_SLVERR;
        end
        if (rvalid_q && rready)
        begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
        if (arvalid && arready_q)
        begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = `HSD_OKAY;
            case ({araddr[7:2], 2'h0})
                `HSD_A_CTRL:  rdata_d = {30'h0, main_q, st_q != hsd_pkg::S_IDLE};
                `HSD_A_INSN:  rdata_d = insn_q;
                `HSD_A_SRC:   rdata_d = src_q;
                `HSD_A_BASE:  rdata_d = base_q;
                `HSD_A_SPLIM: rdata_d = splim_q;
                `HSD_A_STAT:  rdata_d = {24'h0, stat_q};
                `HSD_A_ADDR:  rdata_d = addr_q;
                `HSD_A_WBV:   rdata_d = wbv_q;
                default:
                begin
                    rdata_d = 32'h0;
                    rresp_d = `HSD_SLVERR;
                end
            endcase
        end
    end

    // bus slave registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            awaddr_q  <= 8'h0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `HSD_OKAY;
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= `HSD_OKAY;
        end
        else
        begin
            awready_q <= awready_d;
            wready_q  <= wready_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // execute next state: decode, optional monitor query, then at most one store
    always_comb
    begin
        st_d    = st_q;
        dec_d   = dec_q;
        stat_d  = stat_q;
        main_d  = main_q;
        insn_d  = insn_q;
        src_d   = src_q;
        base_d  = base_q;
        splim_d = splim_q;
        addr_d  = addr_q;
        wbv_d   = wbv_q;
        xq_d    = xq_q;
        xok_d   = xok_q;
        mem_d   = mem_q;
        rwr_d   = rwr_q;
        mem_d.valid = 1'b0;
        rwr_d.valid = 1'b0;
        fault_d = 1'b0;
        // operand words may change while busy; decode and addresses are held, but store data reads src_q live in S_EXEC
        if (wr_fire)
            case ({awaddr_q[7:2], 2'h0})
                `HSD_A_CTRL:
                begin
                    if (wstrb_q[0])
                        main_d = wdata_q[`HSD_B_MAIN];
                    if (wstrb_q[0] && wdata_q[`HSD_B_GO] && st_q == hsd_pkg::S_IDLE)
                    begin
                        st_d   = hsd_pkg::S_DEC;
                        stat_d = '0;
                    end
                end
                `HSD_A_INSN:  insn_d  = hsd_merge(insn_q, wdata_q, wstrb_q);
                `HSD_A_SRC:   src_d   = hsd_merge(src_q, wdata_q, wstrb_q);
                `HSD_A_BASE:  base_d  = hsd_merge(base_q, wdata_q, wstrb_q);
                `HSD_A_SPLIM: splim_d = hsd_merge(splim_q, wdata_q, wstrb_q);
                default:      st_d    = st_d;
            endcase
        case (st_q)
            hsd_pkg::S_DEC:
            begin
                dec_d = dv;
                wbv_d = dv.add ? base_q + dv.imm : base_q - dv.imm; // RULE_13
                addr_d = dv.index ? wbv_d : base_q; // RULE_13
                if (dv.excl)
                    addr_d = base_q; // RULE_01
                if (dv.unpriv || dv.undef || dv.unpred)
                begin
                    // these never touch memory or registers
                    stat_d.done   = 1'b1;
                    stat_d.unpriv = dv.unpriv; // RULE_10
                    stat_d.undef  = dv.undef; // RULE_06 RULE_07
                    stat_d.unpred = dv.unpred; // RULE_03 RULE_12
                    st_d = hsd_pkg::S_IDLE;
                end
                else if (dv.excl)
                begin
                    xq_d = 1'b1;
                    st_d = hsd_pkg::S_EXCL;
                end
                else
                    st_d = hsd_pkg::S_EXEC;
            end
            hsd_pkg::S_EXCL:
                if (excl_done)
                begin
                    xq_d  = 1'b0;
                    xok_d = excl_pass; // RULE_01
                    st_d  = hsd_pkg::S_EXEC;
                end
            hsd_pkg::S_EXEC:
            begin
                st_d        = hsd_pkg::S_IDLE;
                stat_d.done = 1'b1;
                mem_d.addr  = addr_q;
                mem_d.data  = src_q[15:0]; // RULE_16
                mem_d.excl  = dec_q.excl;
                mem_d.align_chk = dec_q.excl; // RULE_17
                if (dec_q.excl)
                begin
                    mem_d.valid = xok_q; // RULE_01
                    stat_d.stored    = xok_q;
                    stat_d.excl_fail = !xok_q;
                    rwr_d = '{valid: 1'b1, idx: dec_q.rd, value: {31'h0, !xok_q},
                              sp_chk: 1'b0}; // RULE_02
                end
                else
                begin
                    mem_d.valid   = !viol; // RULE_14
                    stat_d.stored = !viol;
                    stat_d.wback  = dec_q.wback;
                    if (dec_q.wback && viol)
                    begin
                        fault_d = 1'b1; // RULE_15
                        stat_d.lim_fault = 1'b1;
                    end
                    else if (dec_q.wback)
                        rwr_d = '{valid: 1'b1, idx: dec_q.base_reg, value: wbv_q,
                                  sp_chk: dec_q.base_reg == `HSD_R_SP}; // RULE_15
                end
            end
            default: st_d = st_d;
        endcase
    end

    // execute registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q    <= hsd_pkg::S_IDLE;
            dec_q   <= '0;
            stat_q  <= '0;
            main_q  <= 1'b0;
            insn_q  <= 32'h0;
            src_q   <= 32'h0;
            base_q  <= 32'h0;
            splim_q <= 32'h0;
            addr_q  <= 32'h0;
            wbv_q   <= 32'h0;
            xq_q    <= 1'b0;
            xok_q   <= 1'b0;
            mem_q   <= '0;
            rwr_q   <= '0;
            fault_q <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            dec_q   <= dec_d;
            stat_q  <= stat_d;
            main_q  <= main_d;
            insn_q  <= insn_d;
            src_q   <= src_d;
            base_q  <= base_d;
            splim_q <= splim_d;
            addr_q  <= addr_d;
            wbv_q   <= wbv_d;
            xq_q    <= xq_d;
            xok_q   <= xok_d;
            mem_q   <= mem_d;
            rwr_q   <= rwr_d;
            fault_q <= fault_d;
        end
    end

    assign awready    = awready_q;
    assign wready     = wready_q;
    assign bvalid     = bvalid_q;
    assign bresp      = bresp_q;
    assign arready    = arready_q;
    assign rvalid     = rvalid_q;
    assign rdata      = rdata_q;
    assign rresp      = rresp_q;
    assign mem_o      = mem_q;
    assign excl_query = xq_q;
    assign rwr_o      = rwr_q;
    assign fault_o    = fault_q;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_excl_store: assert property (st_q == hsd_pkg::S_EXEC && dec_q.excl && xok_q |=> // RULE_01
        mem_o.valid && mem_o.excl && mem_o.addr == $past(base_q)
        && mem_o.data == $past(src_q[15:0]))
        else $error("exclusive store wrong");
    chk_excl_status: assert property (st_q == hsd_pkg::S_EXEC && dec_q.excl |=> // RULE_02
        rwr_o.valid && rwr_o.idx == $past(dec_q.rd) && rwr_o.value == {31'h0, !$past(xok_q)})
        else $error("exclusive status wrong");
    chk_bad_nop: assert property (st_q == hsd_pkg::S_DEC && dv.unpred |-> // RULE_03 RULE_12
        ##1 (st_q == hsd_pkg::S_IDLE && stat_q.unpred) [*2] and ##1 !mem_o.valid [*2])
        else $error("unpredictable form stored");
    chk_short_addr: assert property (st_q == hsd_pkg::S_DEC && insn_q[15:11] == `HSD_E_SHORT // RULE_04
        |=> addr_q == $past(base_q) + {26'h0, $past(insn_q[10:6]), 1'b0} && !dec_q.wback)
        else $error("short form address wrong");
    chk_wide_undef: assert property (st_q == hsd_pkg::S_DEC && insn_q[15:4] == `HSD_E_LONG // RULE_06
        && (insn_q[3:0] == `HSD_R_PC || !main_q) |=> stat_q.undef && !mem_o.valid)
        else $error("wide form not undefined");
    chk_unpriv_skip: assert property (st_q == hsd_pkg::S_DEC && insn_q[15:4] == `HSD_E_MODE // RULE_10
        && insn_q[27] && insn_q[26:24] == 3'h6 |=> stat_q.unpriv ##1 !mem_o.valid)
        else $error("unprivileged form executed");
    chk_index_addr: assert property (st_q == hsd_pkg::S_DEC && !dv.excl |=> // RULE_13
        addr_q == (dec_q.index ? wbv_q : $past(base_q)))
        else $error("index selection wrong");
    chk_limit_fault: assert property (st_q == hsd_pkg::S_EXEC && !dec_q.excl && viol |=> // RULE_14
        fault_o && !mem_o.valid && !rwr_o.valid ##1 !fault_o)
        else $error("stack limit not enforced");
    chk_wb_value: assert property (st_q == hsd_pkg::S_EXEC && !dec_q.excl && dec_q.wback // RULE_15
        && !viol |=> rwr_o.valid && rwr_o.value == $past(wbv_q)
        && rwr_o.idx == $past(dec_q.base_reg))
        else $error("writeback wrong");
endmodule : hsd_core

/* File: common/hsd_map.svh */
`ifndef HSD_MAP_SVH
`define HSD_MAP_SVH
// register byte offsets on the control bus
`define HSD_A_CTRL  8'h00
`define HSD_A_INSN  8'h04
`define HSD_A_SRC   8'h08
`define HSD_A_BASE  8'h0c
`define HSD_A_SPLIM 8'h10
`define HSD_A_STAT  8'h14
`define HSD_A_ADDR  8'h18
`define HSD_A_WBV   8'h1c
// control bit positions
`define HSD_B_GO    0
`define HSD_B_MAIN  1
// special register numbers
`define HSD_R_SP    4'hd
`define HSD_R_PC    4'hf
// encoding signatures
`define HSD_E_SHORT 5'h10
`define HSD_E_EXCL  12'he8c
`define HSD_E_EXH2  4'h5
`define HSD_E_LONG  12'hf8a
`define HSD_E_MODE  12'hf82
// bus responses
`define HSD_OKAY    2'h0
`define HSD_SLVERR  2'h2
`endif

/* File: common/hsd_pkg.sv */
package hsd_pkg;
    typedef enum logic [1:0] {S_IDLE, S_DEC, S_EXCL, S_EXEC} hsd_state_t;
    typedef struct packed {
        logic unpriv; logic wback; logic lim_fault; logic excl_fail;
        logic stored; logic unpred; logic undef; logic done;
    } hsd_stat_t;
    typedef struct packed {
        logic excl; logic undef; logic unpred; logic unpriv;
        logic index; logic add; logic wback;
        logic [3:0] base_reg; logic [3:0] source_reg; logic [3:0] rd;
        logic [31:0] imm;
    } hsd_dec_t;
    typedef struct packed {
        logic valid; logic [31:0] addr; logic [15:0] data;
        logic excl; logic align_chk;
    } hsd_mem_t;
    typedef struct packed {
        logic valid; logic [3:0] idx; logic [31:0] value; logic sp_chk;
    } hsd_rwr_t;
endpackage : hsd_pkg

/* File: bench/hsd_mon_model.sv */
`timescale 1ns/1ps
// exclusive monitor model; the memory itself accepts every store pulse
module hsd_mon_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       excl_query,
    input  wire logic       pass_sel,   // verdict to give
    input  wire logic [3:0] dly,        // cycles to stall before answering
    output logic            excl_done,
    output logic            excl_pass
);
    logic [3:0] cnt_q;  // cycles the current query has waited
    logic       ans;    // answer due in this cycle
    assign ans = excl_query && !excl_done && cnt_q == dly;
    // one answer per query; outside the pulse the verdict shows its inverse,
    // so a design that samples it late sees the wrong value
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q     <= 4'h0;
            excl_done <= 1'b0;
            excl_pass <= 1'b0;
        end
        else
        begin
            excl_done <= ans;
            excl_pass <= ans ? pass_sel : !pass_sel;
            cnt_q     <= (excl_query && !excl_done) ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule : hsd_mon_model

/* File: bench/tb.sv */
`timescale 1ns/1ps
`include "hsd_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, excl_query, excl_done, excl_pass;
    logic fault_o, pass_sel;
    logic [7:0] awaddr, araddr, st;
    logic [31:0] wdata, rdata, rdat;
    logic [3:0] wstrb, dly;
    logic [1:0] bresp, rresp, resp;
    hsd_pkg::hsd_mem_t mem_o, mem_q;   // last store seen
    hsd_pkg::hsd_rwr_t rwr_o, rwr_q;   // last register write seen
    int miscompares, total_checks, n_mem, n_rwr, n_flt;
    logic [11:0] xb [7];               // bad exclusive register triples
    hsd_core uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .mem_o, .excl_query, .excl_done,
        .excl_pass, .rwr_o, .fault_o);
    hsd_mon_model mon (.aclk, .aresetn, .excl_query, .pass_sel, .dly,
        .excl_done, .excl_pass);
    always #20 aclk = ~aclk;
    // count the one-cycle pulses in the cycle they stand
    always @(posedge aclk)
    begin
        if (mem_o.valid === 1'b1) begin n_mem++; mem_q <= mem_o; end
        if (rwr_o.valid === 1'b1) begin n_rwr++; rwr_q <= rwr_o; end
        if (fault_o === 1'b1) n_flt++;
    end
    task automatic report_and_stop;
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // bus write: both halves offered at once, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a; wdata <= d; wstrb <= 4'hf;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        resp = bresp;
        if (n >= 50) miscompares++;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rdat = rdata;
        resp = rresp;
        if (n >= 50) miscompares++;
    endtask : rd
    // load operands, start, poll status until done
    task automatic go(input logic [31:0] insn, base, lim, input logic main);
        int n;
        wr(`HSD_A_INSN, insn);
        wr(`HSD_A_BASE, base);
        wr(`HSD_A_SPLIM, lim);
        n_mem = 0; n_rwr = 0; n_flt = 0; st = 8'h00; n = 0;
        wr(`HSD_A_CTRL, {30'h0, main, 1'b1});
        while (st[0] !== 1'b1 && n < 30)
        begin
            rd(`HSD_A_STAT);
            st = rdat[7:0];
            n++;
        end
        if (n >= 30) miscompares++;
    endtask : go
    // status under a mask, store count/address/data, register write
    task automatic chk(input logic [7:0] msk, es, input int nm, input logic [31:0] ma,
        input int nr, input logic [3:0] ri, input logic [31:0] rv);
        `CHK(st & msk, es)
        `CHK(n_mem, nm)
        `CHK(n_rwr, nr)
        if (nm > 0)
        begin
            `CHK(mem_q.addr, ma)
            `CHK(mem_q.data, 16'h1234)
        end
        if (nr > 0)
        begin
            `CHK(rwr_q.idx, ri)
            `CHK(rwr_q.value, rv)
            `CHK(rwr_q.sp_chk, ri == 4'hd)
        end
    endtask : chk
    function automatic logic [31:0] lf(input logic [3:0] base, src, input logic [11:0] im);
        return {src, im, `HSD_E_LONG, base};
    endfunction : lf
    function automatic logic [31:0] mf(input logic [3:0] base, src, input logic [2:0] puw,
        input logic [7:0] im);
        return {src, 1'b1, puw, im, `HSD_E_MODE, base};
    endfunction : mf
    function automatic logic [31:0] xf(input logic [3:0] base, src, rd);
        return {src, 4'hf, `HSD_E_EXH2, rd, `HSD_E_EXCL, base};
    endfunction : xf
    // watchdog: far beyond the fewer than a thousand cycles the sequence needs
    initial
    begin
        #(40 * 20000);
        miscompares++;
        report_and_stop;
    end
    initial
    begin
        logic [31:0] off;
        aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
        rready = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
        pass_sel = 1; dly = 0;
        xb = '{12'h121, 12'h122, 12'h12d, 12'h12f, 12'h1d3, 12'h1f3, 12'hf23};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`HSD_A_CTRL); `CHK(rdat, 32'h0)
        rd(`HSD_A_STAT); `CHK(rdat, 32'h0)
        rd(8'h20); `CHK(resp, `HSD_SLVERR) `CHK(rdat, 32'h0)
        wr(`HSD_A_STAT, 32'hff); `CHK(resp, `HSD_SLVERR)
        wr(`HSD_A_SRC, 32'habcd1234); `CHK(resp, `HSD_OKAY)
        // short form at its largest scaled offset
        go({16'h0, `HSD_E_SHORT, 5'h1f, 3'h1, 3'h2}, 32'h1000, 0, 0);
        chk(8'h4f, 8'h09, 1, 32'h103e, 0, 0, 0);
        `CHK(mem_q.align_chk, 1'b0)
        go(lf(4'h2, 4'h3, 12'hfff), 32'h1000, 0, 1);
        chk(8'h4f, 8'h09, 1, 32'h1fff, 0, 0, 0);
        go(lf(4'h2, 4'h3, 12'hfff), 32'h1000, 0, 0);
        chk(8'h0f, 8'h03, 0, 0, 0, 0, 0);
        go(mf(4'h1, 4'h2, 3'b111, 8'h01), 32'h1000, 0, 0);
        chk(8'h0f, 8'h03, 0, 0, 0, 0, 0);
        go(lf(4'hf, 4'h3, 12'h001), 32'h1000, 0, 1);
        chk(8'h0f, 8'h03, 0, 0, 0, 0, 0);
        go(mf(4'hf, 4'h3, 3'b101, 8'h01), 32'h1000, 0, 1);
        chk(8'h0f, 8'h03, 0, 0, 0, 0, 0);
        for (int i = 13; i < 16; i += 2)
        begin
            go(lf(4'h2, i[3:0], 12'h001), 32'h1000, 0, 1);
            chk(8'h0f, 8'h05, 0, 0, 0, 0, 0);
            go(mf(4'h2, i[3:0], 3'b101, 8'h01), 32'h1000, 0, 1);
            chk(8'h0f, 8'h05, 0, 0, 0, 0, 0);
        end
        go(mf(4'h2, 4'h2, 3'b111, 8'h04), 32'h1000, 0, 1);
        chk(8'h0f, 8'h05, 0, 0, 0, 0, 0);
        // every index/sign/update combination at the largest offset
        for (int k = 0; k < 8; k++)
        begin
            off = k[1] ? 32'h10ff : 32'h0f01;
            go(mf(4'h1, 4'h2, k[2:0], 8'hff), 32'h1000, 0, 1);
            if (k == 6)
                chk(8'h8f, 8'h81, 0, 0, 0, 0, 0);
            else if (!k[2] && !k[0])
                chk(8'h0f, 8'h03, 0, 0, 0, 0, 0);
            else
            begin
                chk(8'h0f, 8'h09, 1, k[2] ? off : 32'h1000, k[0], 4'h1, off);
                rd(`HSD_A_ADDR); `CHK(rdat, k[2] ? off : 32'h1000)
                rd(`HSD_A_WBV); `CHK(rdat, off)
            end
        end
        // stack base: limit met exactly, missed by one, not applied without update
        go(mf(4'hd, 4'h2, 3'b101, 8'h10), 32'h2000, 32'h1ff0, 1);
        chk(8'h2f, 8'h09, 1, 32'h1ff0, 1, 4'hd, 32'h1ff0); `CHK(n_flt, 0)
        go(mf(4'hd, 4'h2, 3'b101, 8'h10), 32'h2000, 32'h1ff1, 1);
        chk(8'h2f, 8'h21, 0, 0, 0, 0, 0); `CHK(n_flt, 1)
        go(mf(4'hd, 4'h2, 3'b100, 8'h10), 32'h2000, 32'hffffffff, 1);
        chk(8'h2f, 8'h09, 1, 32'h1ff0, 0, 0, 0); `CHK(n_flt, 0)
        // exclusive: prompt pass at an odd address, then a slow failure
        go(xf(4'h1, 4'h2, 4'h3), 32'h1001, 0, 0);
        chk(8'h1f, 8'h09, 1, 32'h1001, 1, 4'h3, 32'h0);
        `CHK(mem_q.excl, 1'b1) `CHK(mem_q.align_chk, 1'b1)
        pass_sel <= 1'b0;
        dly      <= 4'h6;
        go(xf(4'h1, 4'h2, 4'h3), 32'h1001, 0, 0);
        chk(8'h1f, 8'h11, 0, 0, 1, 4'h3, 32'h1);
        for (int j = 0; j < 7; j++)
        begin
            go(xf(xb[j][11:8], xb[j][7:4], xb[j][3:0]), 32'h1001, 0, 0);
            chk(8'h1f, 8'h05, 0, 0, 0, 0, 0);
        end
        rd(`HSD_A_BASE); `CHK(rdat, 32'h1001)
        report_and_stop;
    end
endmodule : tb
